// ---- crbi_pkg.sv ----
// Constants for the configuration ROM bus information registers.
package crbi_pkg;
  // ---------------------------------------------------------------
  // Host register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CRBI_HDR_OFS = 8'h18;
  localparam logic [7:0] CRBI_BUSID_OFS = 8'h1C;
  localparam logic [7:0] CRBI_OPT_OFS = 8'h20;
  // ---------------------------------------------------------------
  // Remote bus addresses of the ROM quadlets
  // ---------------------------------------------------------------
  localparam logic [47:0] CRBI_ROM_HDR_ADDR = 48'hFFFF_F000_0400;
  localparam logic [47:0] CRBI_ROM_BUSID_ADDR = 48'hFFFF_F000_0404;
  localparam logic [47:0] CRBI_ROM_OPT_ADDR = 48'hFFFF_F000_0408;
  // ---------------------------------------------------------------
  // Values and field layout
  // ---------------------------------------------------------------
  localparam logic [31:0] CRBI_BUSID_VALUE = 32'h3133_3934;
  localparam logic [15:0] CRBI_HDR_UPPER_RST = 16'h0000;
  localparam logic [15:0] CRBI_CRC_RST = 16'h0000;
  localparam logic [4:0] CRBI_CAPS_RST = 5'h00;
  localparam logic [7:0] CRBI_ACC_RST = 8'h00;
  localparam logic [3:0] CRBI_MAXREC_RST = 4'hA;
  localparam logic [3:0] CRBI_MAXREC_MIN = 4'h8;
  localparam logic [1:0] CRBI_OPT_MID_RST = 2'h0;
  localparam logic [2:0] CRBI_OPT_RSVD_HI = 3'h0;
  localparam logic [3:0] CRBI_OPT_RSVD_MID = 4'h0;
  localparam logic [5:0] CRBI_OPT_LOW_RO = 6'h02;
  localparam logic [31:0] CRBI_ZERO_WORD = 32'h0000_0000;
  localparam logic [16:0] CRBI_BYTES_ONE = 17'h00002;
endpackage

// ---- crbi_regs.sv ----
// Configuration ROM header, bus identification and bus options registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Header sits at host offset 18h and answers remote reads of ROM quadlet 0400h.
// - Header is fully host writable; upper half resets to zero.
// - CRC value must stay valid while link on; software or EEPROM keeps it.
// - With an EEPROM present the CRC value is loaded from it after reset.
// - Bus identification at 1Ch is read only and always 3133 3934h.
// - Bus options at 20h answer remote reads of the second info quadlet.
// - Options bits 31-27 are writable capability flags; bits 26-24 read zero.
// - Options bits 23-16 hold writable cycle master clock accuracy.
// - Max request field encodes 2^(n+1) bytes, at least 512, 2048 at reset.
// - Block writes longer than the maximum request may get a type error.
module crbi_regs
  import crbi_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  // Host register port
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [31:0] host_wdata_i,
  output logic [31:0] host_rdata_o,
  // Remote configuration ROM reads
  input wire logic rom_rd_i,
  input wire logic [47:0] rom_addr_i,
  output logic [31:0] rom_rdata_o,
  // Serial EEPROM preload
  input wire logic eeprom_present_i,
  input wire logic eeprom_load_i,
  input wire logic [15:0] eeprom_crc_i,
  // Link state and received block writes
  input wire logic link_on_bit_i,
  input wire logic blk_wr_i,
  input wire logic [15:0] blk_wr_len_i,
  output logic type_error_o,
  output logic [3:0] max_rec_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] hdr_upper;
    logic [15:0] crc;
    logic [4:0] caps;
    logic [7:0] acc;
    logic [3:0] max_rec;
    logic [1:0] opt_mid;
    logic [31:0] host_rdata;
    logic [31:0] rom_rdata;
    logic type_err;
  } crbi_state_type;

  crbi_state_type state_reg;
  crbi_state_type state_next;

  function automatic logic [16:0] crbi_rec_bytes(input logic [3:0] rec);
    crbi_rec_bytes = CRBI_BYTES_ONE << rec;
  endfunction

  function automatic logic [31:0] crbi_opt_word(input crbi_state_type s);
    crbi_opt_word = {s.caps, CRBI_OPT_RSVD_HI, s.acc, s.max_rec, CRBI_OPT_RSVD_MID,
                     s.opt_mid, CRBI_OPT_LOW_RO};
  endfunction

  logic [31:0] hdr_word;
  logic [31:0] opt_word;
  assign hdr_word = {state_reg.hdr_upper, state_reg.crc};
  assign opt_word = crbi_opt_word(state_reg);

  // A received block write that is longer than the current maximum request.
  logic blk_over;
  assign blk_over = blk_wr_i && ({1'b0, blk_wr_len_i} > crbi_rec_bytes(state_reg.max_rec));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.type_err = 1'b0;
    if (soft_reset_i) begin
      // The maximum request field survives a software reset.
      state_next.hdr_upper = CRBI_HDR_UPPER_RST;
      state_next.caps = CRBI_CAPS_RST;
      state_next.acc = CRBI_ACC_RST;
      state_next.opt_mid = CRBI_OPT_MID_RST;
    end
    if (host_wr_i) begin
      case (host_addr_i)
        CRBI_HDR_OFS: begin
          state_next.hdr_upper = host_wdata_i[31:16];
          state_next.crc = host_wdata_i[15:0];
        end
        CRBI_OPT_OFS: begin
          state_next.caps = host_wdata_i[31:27];
          state_next.acc = host_wdata_i[23:16];
          state_next.opt_mid = host_wdata_i[7:6];
          // A value under 512 bytes is refused so the field stays legal.
          if (host_wdata_i[15:12] >= CRBI_MAXREC_MIN) begin
            state_next.max_rec = host_wdata_i[15:12];
          end
        end
        default: begin
          // Bus identification and unmapped offsets keep no state.
          state_next.hdr_upper = state_next.hdr_upper;
        end
      endcase
    end
    // The EEPROM load wins over a host write in the same cycle.
    if (eeprom_load_i && eeprom_present_i) begin
      state_next.crc = eeprom_crc_i;
    end
    if (host_rd_i) begin
      case (host_addr_i)
        CRBI_HDR_OFS: state_next.host_rdata = hdr_word;
        CRBI_BUSID_OFS: state_next.host_rdata = CRBI_BUSID_VALUE;
        CRBI_OPT_OFS: state_next.host_rdata = opt_word;
        default: state_next.host_rdata = CRBI_ZERO_WORD;
      endcase
    end
    if (rom_rd_i) begin
      case (rom_addr_i)
        CRBI_ROM_HDR_ADDR: state_next.rom_rdata = hdr_word;
        CRBI_ROM_BUSID_ADDR: state_next.rom_rdata = CRBI_BUSID_VALUE;
        CRBI_ROM_OPT_ADDR: state_next.rom_rdata = opt_word;
        default: state_next.rom_rdata = CRBI_ZERO_WORD;
      endcase
    end
    if (blk_over) begin
      state_next.type_err = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg.hdr_upper <= CRBI_HDR_UPPER_RST;
      state_reg.crc <= CRBI_CRC_RST;
      state_reg.caps <= CRBI_CAPS_RST;
      state_reg.acc <= CRBI_ACC_RST;
      state_reg.max_rec <= CRBI_MAXREC_RST;
      state_reg.opt_mid <= CRBI_OPT_MID_RST;
      state_reg.host_rdata <= CRBI_ZERO_WORD;
      state_reg.rom_rdata <= CRBI_ZERO_WORD;
      state_reg.type_err <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign host_rdata_o = state_reg.host_rdata;
  assign rom_rdata_o = state_reg.rom_rdata;
  assign type_error_o = state_reg.type_err;
  assign max_rec_o = state_reg.max_rec;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_rom_hdr_rd;
    rom_rd_i && (rom_addr_i == CRBI_ROM_HDR_ADDR);
  endsequence
  sequence s_rom_opt_rd;
    rom_rd_i && (rom_addr_i == CRBI_ROM_OPT_ADDR);
  endsequence

  property p_rom_hdr;
    s_rom_hdr_rd |=> (rom_rdata_o == $past(hdr_word));
  endproperty
  a_rom_hdr: assert property (p_rom_hdr) else $error("ROM header read wrong");

  property p_hdr_write;
    (host_wr_i && host_addr_i == CRBI_HDR_OFS && !eeprom_load_i)
      |=> (hdr_word == $past(host_wdata_i));
  endproperty
  a_hdr_write: assert property (p_hdr_write) else $error("Header write lost");

  property p_eeprom;
    (eeprom_load_i && eeprom_present_i) |=> (state_reg.crc == $past(eeprom_crc_i));
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("EEPROM CRC not loaded");

  property p_busid;
    (host_rd_i && host_addr_i == CRBI_BUSID_OFS) |=> (host_rdata_o == CRBI_BUSID_VALUE);
  endproperty
  a_busid: assert property (p_busid) else $error("Bus id not constant");

  property p_rom_busid;
    (rom_rd_i && rom_addr_i == CRBI_ROM_BUSID_ADDR) |=> (rom_rdata_o == CRBI_BUSID_VALUE);
  endproperty
  a_rom_busid: assert property (p_rom_busid) else $error("ROM bus id not constant");

  // While the link is on, only a header write or an EEPROM load may move the CRC value.
  property p_crc_hold;
    (link_on_bit_i && !(host_wr_i && host_addr_i == CRBI_HDR_OFS) &&
      !(eeprom_load_i && eeprom_present_i)) |=> $stable(state_reg.crc);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("CRC value disturbed");

  property p_rom_opt;
    s_rom_opt_rd |=> (rom_rdata_o == $past(opt_word));
  endproperty
  a_rom_opt: assert property (p_rom_opt) else $error("ROM options read wrong");

  property p_opt_zero;
    (host_rd_i && host_addr_i == CRBI_OPT_OFS) |=> (host_rdata_o[26:24] == CRBI_OPT_RSVD_HI);
  endproperty
  a_opt_zero: assert property (p_opt_zero) else $error("Options reserved bits set");

  property p_acc;
    (host_wr_i && host_addr_i == CRBI_OPT_OFS) |=> (state_reg.acc == $past(host_wdata_i[23:16]))
      && (state_reg.caps == $past(host_wdata_i[31:27]));
  endproperty
  a_acc: assert property (p_acc) else $error("Options write lost");

  property p_maxrec;
    (soft_reset_i && !host_wr_i) |=> $stable(state_reg.max_rec) &&
      (state_reg.max_rec >= CRBI_MAXREC_MIN);
  endproperty
  a_maxrec: assert property (p_maxrec) else $error("Max request disturbed");

  property p_type_err;
    blk_over |=> type_error_o;
  endproperty
  a_type_err: assert property (p_type_err) else $error("Type error missing");

  property p_type_quiet;
    !blk_over |=> !type_error_o;
  endproperty
  a_type_quiet: assert property (p_type_quiet) else $error("Spurious type error");

endmodule
`default_nettype wire

// ---- crbi_remote_node.sv ----
// Remote serial-bus node that reads configuration ROM quadlets.
`timescale 1ns/1ps
`default_nettype none
module crbi_remote_node (
  // Clock
  input wire logic mclk_i,
  // ROM read request and answer
  output logic rom_rd_o,
  output logic [47:0] rom_addr_o,
  input wire logic [31:0] rom_rdata_i
);
  initial begin
    rom_rd_o = 1'b0;
    rom_addr_o = 48'h0000_0000_0000;
  end
  // The address is inverted once released, so a stale address cannot pass for a held one.
  task automatic fetch(input logic [47:0] a, output logic [31:0] d);
    @(negedge mclk_i);
    rom_rd_o = 1'b1;
    rom_addr_o = a;
    @(negedge mclk_i);
    rom_rd_o = 1'b0;
    rom_addr_o = ~a;
    d = rom_rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the configuration ROM bus information registers.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crbi_pkg::*;
  logic clk = 0, rst_n = 0, srst = 0, wr = 0, rd = 0, rr, ep = 0, el = 0, lk = 0, bw = 0, te;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rrd, q;
  logic [47:0] ra;
  logic [15:0] ec = 16'h0, bl = 16'h0;
  logic [3:0] mr;
  int err_count = 0, cmp_count = 0, cyc = 0;
  // ---------------------------------------------------------------
  // Clock, timeout and instances
  // ---------------------------------------------------------------
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  crbi_regs dut (.mclk_i(clk), .reset_n_i(rst_n), .soft_reset_i(srst), .host_addr_i(ad),
    .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wd), .host_rdata_o(rdat), .rom_rd_i(rr),
    .rom_addr_i(ra), .rom_rdata_o(rrd), .eeprom_present_i(ep), .eeprom_load_i(el),
    .eeprom_crc_i(ec), .link_on_bit_i(lk), .blk_wr_i(bw), .blk_wr_len_i(bl),
    .type_error_o(te), .max_rec_o(mr));
  crbi_remote_node node (.mclk_i(clk), .rom_rd_o(rr), .rom_addr_o(ra), .rom_rdata_i(rrd));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrq(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    ad = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rdq(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    rd = 1'b1;
    ad = a;
    @(negedge clk);
    rd = 1'b0;
    chk(rdat, e);
  endtask
  task automatic blk(input logic [15:0] n, input logic e);
    @(negedge clk);
    bw = 1'b1;
    bl = n;
    @(negedge clk);
    bw = 1'b0;
    chk({31'h0, te}, {31'h0, e});
  endtask
  task automatic eload(input logic present, input logic [15:0] v);
    ep = present;
    @(negedge clk);
    el = 1'b1;
    ec = v;
    @(negedge clk);
    el = 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rdq(CRBI_HDR_OFS, 32'h0000_0000);
    rdq(CRBI_OPT_OFS, 32'h0000_A002);
    chk({28'h0, mr}, 32'h0000_000A);
  endtask
  task automatic t_header();
    wrq(CRBI_HDR_OFS, 32'hABCD_5678);
    lk = 1'b1;
    rdq(CRBI_HDR_OFS, 32'hABCD_5678);
    node.fetch(CRBI_ROM_HDR_ADDR, q);
    chk(q, 32'hABCD_5678);
  endtask
  task automatic t_busid();
    wrq(CRBI_BUSID_OFS, 32'h0000_0000);
    rdq(CRBI_BUSID_OFS, 32'h3133_3934);
    node.fetch(CRBI_ROM_BUSID_ADDR, q);
    chk(q, 32'h3133_3934);
    rdq(8'h24, 32'h0000_0000);
    node.fetch(48'hFFFF_F000_040C, q);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_options();
    wrq(CRBI_OPT_OFS, 32'hFFFF_FFFF);
    rdq(CRBI_OPT_OFS, 32'hF8FF_F0C2);
    node.fetch(CRBI_ROM_OPT_ADDR, q);
    chk(q, 32'hF8FF_F0C2);
    // A field below 512 bytes is refused while the rest of the word is taken.
    wrq(CRBI_OPT_OFS, 32'h0012_7000);
    rdq(CRBI_OPT_OFS, 32'h0012_F002);
    wrq(CRBI_OPT_OFS, 32'h0000_8000);
    chk({28'h0, mr}, 32'h0000_0008);
    blk(16'h0200, 1'b0);
    blk(16'h0201, 1'b1);
  endtask
  task automatic t_eeprom();
    eload(1'b1, 16'h1234);
    rdq(CRBI_HDR_OFS, 32'hABCD_1234);
    eload(1'b0, 16'h5555);
    rdq(CRBI_HDR_OFS, 32'hABCD_1234);
  endtask
  task automatic t_soft();
    wrq(CRBI_OPT_OFS, 32'hFFFF_FFFF);
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    rdq(CRBI_HDR_OFS, 32'h0000_1234);
    rdq(CRBI_OPT_OFS, 32'h0000_F002);
  endtask
  task automatic t_hwreset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk({28'h0, mr}, 32'h0000_000A);
    rdq(CRBI_HDR_OFS, 32'h0000_0000);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_header();
    t_busid();
    t_options();
    t_eeprom();
    t_soft();
    t_hwreset();
    conclude();
  end
endmodule
`default_nettype wire
